// ### design/sqm_regs.vh
// Constants for the serial master with its documented corner-case behaviour
`ifndef SQM_REGS_VH
`define SQM_REGS_VH

// ----------------------------------------
// Transmit word layout
// ----------------------------------------
`define SQM_TXW_DATA_MSB   15
`define SQM_TXW_PCS_LSB    16
`define SQM_TXW_PCS_MSB    17
`define SQM_TXW_FINAL_BIT  24

// ----------------------------------------
// Transfer length field (length = 8 + field)
// ----------------------------------------
`define SQM_BITS_BASE      5'h08
`define SQM_BITS_FIELD_8   4'h0

// ----------------------------------------
// Reset values and figures
// ----------------------------------------
`define SQM_DIV_ONE        8'h01
`define SQM_DUP_RST        1'b0
`define SQM_EXTRA_HALVES   2'h2

// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define SQM_ST_IDLE        3'h0
`define SQM_ST_PRECLK      3'h1
`define SQM_ST_LEAD        3'h2
`define SQM_ST_SHIFT       3'h3
`define SQM_ST_EXTRA       3'h4

`endif

// ### design/sqm_master.v
// Serial master core reproducing the documented clocking, select and reset quirks
//
// What this block does
// - Odd divider above 1, polarity 1, phase 0: extra pulse
// - Hold set, divider 1, same select after idle: repeat word
// - Fixed channel mode: final flag releases select when drained
// - Channel word size follows select 0 length in fixed channel mode
// - Divider 1 with odd length: extra pulse
// - Soft reset lost on transmit-ready event
// - Single soft reset: clock before select
// - Polarity 1, phase 0, slow then divider-1 select: extra pulse
`timescale 1ns/1ps
`include "sqm_regs.vh"

module sqm_master #(
   parameter NCS = 4                                   // Number of chip selects
) (
   input  wire             clk_in,                     // 40 MHz system clock
   input  wire             rst_n_in,                   // Async reset, active low
   input  wire             soft_reset_cmd_in,          // Control register soft reset pulse
   input  wire             fixed_select_in,            // 1: fixed peripheral selection
   input  wire [1:0]       select_in,                  // Fixed selection index
   input  wire             channel_mode_in,            // Words fed by transfer channel
   input  wire [8*NCS-1:0] clock_divider_in,           // Per-select divider
   input  wire [NCS-1:0]   clock_polarity_in,          // Per-select idle level
   input  wire [NCS-1:0]   phase_inverse_in,           // Per-select phase
   input  wire [4*NCS-1:0] bits_field_in,              // Per-select length field
   input  wire [NCS-1:0]   cs_hold_after_transfer_in,  // Per-select hold
   input  wire [31:0]      tx_word_in,                 // Transmit word
   input  wire             tx_valid_in,                // Transmit word offered
   input  wire             miso_in,                    // Serial data from slave (async)
   output wire             transmit_ready_flag_out,    // Word may be written
   output wire             transmit_drained_flag_out,  // Nothing left to send
   output wire             channel_halfword_out,       // Word size told to channel
   output reg              serial_clock_out,           // Serial clock
   output reg              mosi_out,                   // Serial data to slave
   output reg  [NCS-1:0]   cs_n_out,                   // Chip selects, active low
   output reg  [15:0]      rx_data_out,                // Received word
   output reg              rx_valid_out                // Received word pulse
);

   // ----------------------------------------
   // Reset and input synchronisers
   // ----------------------------------------
   reg        rst_s1_r;                                // Reset sync first stage
   reg        rst_s2_r;                                // Reset used by the core
   reg        miso_s1_r;                               // Data sync first stage
   reg        miso_s2_r;                               // Data seen by logic

   // Release reset through two flops
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   // Slave data comes from another domain
   always @(posedge clk_in or negedge rst_s2_r) begin
      if (!rst_s2_r) begin
         miso_s1_r <= 1'b0;
         miso_s2_r <= 1'b0;
      end else begin
         miso_s1_r <= miso_in;
         miso_s2_r <= miso_s1_r;
      end
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg [2:0]  state_r;                                 // Sequencer state
   reg [1:0]  cs_idx_r;                                // Select of current transfer
   reg [15:0] shift_r;                                 // Outgoing data
   reg [15:0] word_r;                                  // Copy for repeat
   reg [15:0] rx_r;                                    // Incoming data
   reg [5:0]  half_r;                                  // Half periods left
   reg [7:0]  dcnt_r;                                  // Divider counter
   reg        final_r;                                 // Final flag of current word
   reg        dup_r;                                   // Repeat current word once
   reg        extra_r;                                 // Extra pulse owed
   reg        held_r;                                  // Select kept asserted
   reg        gap_r;                                   // Idle time since last word
   reg [7:0]  prev_div_r;                              // Divider of previous transfer
   reg        misorder_r;                              // Single soft reset seen
   reg        ready_d_r;                               // Ready one cycle ago

   // ----------------------------------------
   // Per-select configuration views
   // ----------------------------------------
   wire [1:0] new_idx    = fixed_select_in ? select_in : tx_word_in[`SQM_TXW_PCS_MSB:`SQM_TXW_PCS_LSB];
   wire [7:0] new_div    = clock_divider_in[8*new_idx +: 8];
   wire       new_pol    = clock_polarity_in[new_idx];
   wire       new_pha    = phase_inverse_in[new_idx];
   wire [3:0] new_bits   = bits_field_in[4*new_idx +: 4];
   wire       new_hold   = cs_hold_after_transfer_in[new_idx];
   wire [7:0] cur_div    = clock_divider_in[8*cs_idx_r +: 8];
   wire       cur_pol    = clock_polarity_in[cs_idx_r];
   wire       cur_pha    = phase_inverse_in[cs_idx_r];
   wire       cur_hold   = cs_hold_after_transfer_in[cs_idx_r];
   // Length of the select in use; the offered word may already name another select
   wire [4:0] cur_len    = `SQM_BITS_BASE + {1'b0, bits_field_in[4*cs_idx_r +: 4]};
   wire [4:0] new_len    = `SQM_BITS_BASE + {1'b0, new_bits};
   wire       new_div1   = (new_div == `SQM_DIV_ONE);
   wire       pol1_pha0  = new_pol & ~new_pha;

   // Divider tick; zero behaves as one
   wire       tick       = (dcnt_r <= `SQM_DIV_ONE) || (dcnt_r == 8'h00);

   // Handshake and status
   wire       idle       = (state_r == `SQM_ST_IDLE);
   wire       take       = idle & tx_valid_in;
   assign transmit_ready_flag_out   = idle;
   assign transmit_drained_flag_out = idle & ~tx_valid_in;
   wire       ready_evt  = idle & ~ready_d_r;

   // Channel word size from select 0 in fixed channel mode
   wire [3:0] size_field = (fixed_select_in & channel_mode_in) ? bits_field_in[3:0]
                                                               : bits_field_in[4*cs_idx_r +: 4];
   assign channel_halfword_out = (size_field != `SQM_BITS_FIELD_8);

   // Soft reset is lost when it meets a ready event
   wire       sreset     = soft_reset_cmd_in & ~ready_evt;

   // Early release: final flag presented while drained
   wire       early_rel  = idle & held_r & fixed_select_in & channel_mode_in & cur_hold
                           & tx_valid_in & tx_word_in[`SQM_TXW_FINAL_BIT];

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // One process keeps clock, data and selects aligned to the same ticks
   always @(posedge clk_in or negedge rst_s2_r) begin
      if (!rst_s2_r) begin
         state_r          <= `SQM_ST_IDLE;
         cs_idx_r         <= 2'h0;
         shift_r          <= 16'h0000;
         word_r           <= 16'h0000;
         rx_r             <= 16'h0000;
         half_r           <= 6'h00;
         dcnt_r           <= 8'h00;
         final_r          <= 1'b0;
         dup_r            <= `SQM_DUP_RST;
         extra_r          <= 1'b0;
         held_r           <= 1'b0;
         gap_r            <= 1'b0;
         prev_div_r       <= `SQM_DIV_ONE;
         misorder_r       <= 1'b0;
         ready_d_r        <= 1'b1;                     // Idle after reset, so no false ready event
         serial_clock_out <= 1'b0;
         mosi_out         <= 1'b0;
         cs_n_out         <= {NCS{1'b1}};
         rx_data_out      <= 16'h0000;
         rx_valid_out     <= 1'b0;
      end else begin
         ready_d_r    <= idle;
         rx_valid_out <= 1'b0;
         dcnt_r       <= tick ? cur_div : dcnt_r - 8'h01;
         if (sreset) begin
            // Accepted soft reset; a second one in a row clears the quirk
            state_r          <= `SQM_ST_IDLE;
            misorder_r       <= ~misorder_r;
            held_r           <= 1'b0;
            dup_r            <= 1'b0;
            extra_r          <= 1'b0;
            serial_clock_out <= 1'b0;
            cs_n_out         <= {NCS{1'b1}};
         end else begin
            case (state_r)
               `SQM_ST_IDLE: begin
                  if (!take) begin
                     gap_r <= held_r;
                  end
                  if (early_rel) begin
                     cs_n_out <= {NCS{1'b1}};
                     held_r   <= 1'b0;
                  end else if (take) begin
                     cs_idx_r         <= new_idx;
                     shift_r          <= tx_word_in[`SQM_TXW_DATA_MSB:0] << (5'h10 - new_len);
                     word_r           <= tx_word_in[`SQM_TXW_DATA_MSB:0] << (5'h10 - new_len);
                     half_r           <= {new_len, 1'b0};
                     final_r          <= tx_word_in[`SQM_TXW_FINAL_BIT];
                     dcnt_r           <= new_div;
                     serial_clock_out <= new_pol;
                     prev_div_r       <= new_div;
                     // Repeat when hold, divider 1, same slave after idle
                     dup_r   <= held_r & gap_r & new_hold & new_div1 & (new_idx == cs_idx_r);
                     // Extra pulse sources
                     extra_r <= (pol1_pha0 & new_div[0] & ~new_div1)
                              | (new_div1 & new_len[0])
                              | (pol1_pha0 & new_div1 & (prev_div_r > `SQM_DIV_ONE));
                     gap_r   <= 1'b0;
                     if (held_r && new_idx != cs_idx_r) begin
                        cs_n_out <= {NCS{1'b1}};
                     end
                     if (misorder_r) begin
                        // Clock runs before the select is driven
                        state_r <= `SQM_ST_PRECLK;
                        half_r  <= {4'h0, `SQM_EXTRA_HALVES};
                     end else begin
                        state_r <= `SQM_ST_LEAD;
                     end
                  end
               end
               `SQM_ST_PRECLK: begin
                  if (tick) begin
                     serial_clock_out <= ~serial_clock_out;
                     half_r           <= half_r - 6'h01;
                     if (half_r == 6'h01) begin
                        misorder_r <= 1'b0;
                        half_r     <= {cur_len, 1'b0};
                        state_r    <= `SQM_ST_LEAD;
                     end
                  end
               end
               `SQM_ST_LEAD: begin
                  // Drive select and first bit, wait one tick
                  cs_n_out <= ~({{(NCS-1){1'b0}}, 1'b1} << cs_idx_r);
                  mosi_out <= shift_r[15];
                  if (tick) begin
                     state_r <= `SQM_ST_SHIFT;
                  end
               end
               `SQM_ST_SHIFT: begin
                  if (tick) begin
                     serial_clock_out <= ~serial_clock_out;
                     half_r           <= half_r - 6'h01;
                     // Leading edge samples when phase inverse set, else trailing
                     if (half_r[0] == ~cur_pha) begin
                        rx_r <= {rx_r[14:0], miso_s2_r};
                     end else begin
                        shift_r  <= {shift_r[14:0], 1'b0};
                        // Phase 0 drives each bit on its leading edge, phase 1 on the trailing one
                        mosi_out <= cur_pha ? shift_r[14] : shift_r[15];
                     end
                     if (half_r == 6'h01) begin
                        rx_data_out  <= (half_r[0] == ~cur_pha) ? {rx_r[14:0], miso_s2_r} : rx_r;
                        rx_valid_out <= 1'b1;
                        if (dup_r) begin
                           // Same word goes out once more
                           dup_r   <= 1'b0;
                           shift_r <= word_r;
                           half_r  <= {cur_len, 1'b0};
                           state_r <= `SQM_ST_LEAD;
                        end else if (extra_r) begin
                           half_r  <= {4'h0, `SQM_EXTRA_HALVES};
                           state_r <= `SQM_ST_EXTRA;
                        end else begin
                           state_r  <= `SQM_ST_IDLE;
                           held_r   <= cur_hold & ~final_r;
                           cs_n_out <= (cur_hold & ~final_r) ? cs_n_out : {NCS{1'b1}};
                        end
                     end
                  end
               end
               `SQM_ST_EXTRA: begin
                  // Spurious pulse with no data behind it
                  if (tick) begin
                     serial_clock_out <= ~serial_clock_out;
                     half_r           <= half_r - 6'h01;
                     if (half_r == 6'h01) begin
                        extra_r  <= 1'b0;
                        state_r  <= `SQM_ST_IDLE;
                        held_r   <= cur_hold & ~final_r;
                        cs_n_out <= (cur_hold & ~final_r) ? cs_n_out : {NCS{1'b1}};
                     end
                  end
               end
               default: begin
                  state_r <= `SQM_ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// ### dv/sqm_slave_model.sv
// Behavioural slave device on the serial side of the master
`timescale 1ns/1ps
module sqm_slave_model (
   input  wire        clk_in,             // System clock, used to sample the serial lines
   input  wire        sclk_in,            // Serial clock from the master
   input  wire        mosi_in,            // Serial data from the master
   input  wire        idle_in,            // 1: no select asserted
   input  wire        pol_in,             // Idle level of the active select
   output reg         miso_out = 1'b0,    // Serial data back to the master
   output reg  [15:0] n_sel_out = 16'h0,  // Leading edges seen while selected
   output reg  [15:0] n_uns_out = 16'h0,  // Leading edges seen while unselected
   output reg  [15:0] cap_out = 16'h0     // Bits captured on leading edges
);
   reg        sclk_q = 1'b0;              // Serial clock one cycle back
   reg [15:0] pat = 16'hc3a5;             // Reply pattern
   // Leading edges only, so an idle level change is never counted
   wire       lead = (sclk_q == pol_in) && (sclk_in != pol_in);

   // ----------------------------------------
   // Sampling and reply
   // ----------------------------------------
   always @(posedge clk_in) begin
      sclk_q <= sclk_in;
      if (lead && idle_in) n_uns_out <= n_uns_out + 16'h1;
      if (lead && !idle_in) n_sel_out <= n_sel_out + 16'h1;
      if (lead && !idle_in) cap_out <= {cap_out[14:0], mosi_in};
      // Released line toggles so a stale value is never read as data
      if (idle_in) miso_out <= ~miso_out;
      else if (sclk_in != sclk_q) miso_out <= pat[15];
      if (!idle_in && sclk_in != sclk_q) pat <= {pat[14:0], pat[15]};
   end
endmodule

// ### dv/sqm_master_checker.sv
// Port-level assertions for the serial master
`timescale 1ns/1ps
module sqm_master_checker #(
   parameter NCS = 4
) (
   input wire             clk_in,
   input wire             rst_n_in,
   input wire             soft_reset_cmd_in,
   input wire             fixed_select_in,
   input wire [1:0]       select_in,
   input wire             channel_mode_in,
   input wire [4*NCS-1:0] bits_field_in,
   input wire [NCS-1:0]   cs_hold_after_transfer_in,
   input wire [31:0]      tx_word_in,
   input wire             tx_valid_in,
   input wire             transmit_ready_flag_out,
   input wire             transmit_drained_flag_out,
   input wire             channel_halfword_out,
   input wire             serial_clock_out,
   input wire [NCS-1:0]   cs_n_out,
   input wire             rx_valid_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   wire rdy = transmit_ready_flag_out;  // Sequencer idle
   // Held select with a final-flag word offered in channel mode
   wire er = rdy && fixed_select_in && channel_mode_in && tx_valid_in && tx_word_in[24] &&
             cs_hold_after_transfer_in[select_in] && !cs_n_out[select_in] && !soft_reset_cmd_in;

   srst_clear_a:
      assert property (soft_reset_cmd_in && !(rdy && !$past(rdy)) |=> (&cs_n_out) && !serial_clock_out)
      else $error("accepted soft reset left a select or clock active");
   early_release_a:
      assert property (er |=> cs_n_out[$past(select_in)] && rdy)
      else $error("held select not released by final flag");
   drained_flag_a:
      assert property (transmit_drained_flag_out == (rdy && !tx_valid_in))
      else $error("drained flag wrong");
   halfword_cs0_a:
      assert property (fixed_select_in && channel_mode_in |-> channel_halfword_out == (bits_field_in[3:0] != 4'h0))
      else $error("word size not taken from select 0");
   take_busy_a:
      assert property (rdy && tx_valid_in && !tx_word_in[24] && !soft_reset_cmd_in |=> (!rdy) [*8])
      else $error("taken word finished too early");
   one_select_a:
      assert property ($onehot0(~cs_n_out))
      else $error("more than one select asserted");
   rx_pulse_a:
      assert property (rx_valid_out |=> !rx_valid_out)
      else $error("receive pulse longer than one cycle");
   rx_busy_a:
      assert property (rx_valid_out |-> !$past(rdy))
      else $error("receive pulse without a transfer");
   cover property (rx_valid_out && !tx_valid_in && cs_hold_after_transfer_in[select_in]);
   cover property (er);
   cover property (soft_reset_cmd_in && rdy && !$past(rdy));
endmodule

bind sqm_master sqm_master_checker #(.NCS(NCS)) u_chk (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .soft_reset_cmd_in(soft_reset_cmd_in),
   .fixed_select_in(fixed_select_in), .select_in(select_in), .channel_mode_in(channel_mode_in),
   .bits_field_in(bits_field_in), .cs_hold_after_transfer_in(cs_hold_after_transfer_in),
   .tx_word_in(tx_word_in), .tx_valid_in(tx_valid_in), .transmit_ready_flag_out(transmit_ready_flag_out),
   .transmit_drained_flag_out(transmit_drained_flag_out), .channel_halfword_out(channel_halfword_out),
   .serial_clock_out(serial_clock_out), .cs_n_out(cs_n_out), .rx_valid_out(rx_valid_out));

// ### dv/tb.sv
// Self-checking testbench for the serial master
`timescale 1ns/1ps
module tb;
   reg         clk_in = 1'b0;
   reg         rst_n_in = 1'b0;
   reg         srst = 1'b0;          // Soft reset command
   reg  [1:0]  sel = 2'h0;           // Fixed select index
   reg  [31:0] div = 32'h01010101;   // Dividers, byte per select
   reg  [3:0]  pol = 4'h0;
   reg  [3:0]  pha = 4'hf;
   reg  [15:0] fld = 16'h0;          // Length fields
   reg  [3:0]  hold = 4'h0;
   reg  [31:0] word = 32'h0;
   reg         valid = 1'b0;
   reg         fix = 1'b1;           // Fixed selection
   reg         chm = 1'b1;           // Words fed by transfer channel
   reg  [15:0] n_rx = 16'h0;         // Receive pulses seen
   reg  [15:0] s0, u0, r0;
   wire        rdy, drn, half, sclk, mosi, miso, rxv;
   wire [3:0]  cs_n;
   wire [15:0] rxd, n_sel, n_uns, cap;
   integer     fails = 0;
   integer     n_tests = 0;
   integer     i;

   initial forever #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) if (rxv) n_rx <= n_rx + 16'h1;

   sqm_master dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .soft_reset_cmd_in(srst), .fixed_select_in(fix),
      .select_in(sel), .channel_mode_in(chm), .clock_divider_in(div), .clock_polarity_in(pol),
      .phase_inverse_in(pha), .bits_field_in(fld), .cs_hold_after_transfer_in(hold), .tx_word_in(word),
      .tx_valid_in(valid), .miso_in(miso), .transmit_ready_flag_out(rdy), .transmit_drained_flag_out(drn),
      .channel_halfword_out(half), .serial_clock_out(sclk), .mosi_out(mosi), .cs_n_out(cs_n),
      .rx_data_out(rxd), .rx_valid_out(rxv));
   sqm_slave_model u_slave (.clk_in(clk_in), .sclk_in(sclk), .mosi_in(mosi), .idle_in(&cs_n),
      .pol_in(pol[sel]), .miso_out(miso), .n_sel_out(n_sel), .n_uns_out(n_uns), .cap_out(cap));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task end_sim;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, fails);
         if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [15:0] exp, input [15:0] got);
      begin
         n_tests = n_tests + 1;
         if (exp !== got) begin
            fails = fails + 1;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
         end
      end
   endtask
   // Select k becomes the fixed one; settle before any transfer
   task cfg(input [1:0] k, input [7:0] d, input p, input ph, input [3:0] f, input h);
      begin
         @(negedge clk_in);
         div[8*k +: 8] = d;
         pol[k] = p;
         pha[k] = ph;
         fld[4*k +: 4] = f;
         hold[k] = h;
         sel = k;
         repeat (3) @(negedge clk_in);
      end
   endtask
   task pulse;
      begin
         @(negedge clk_in);
         srst = 1'b1;
         @(negedge clk_in);
         srst = 1'b0;
      end
   endtask
   // One word: leading edges selected and unselected, receive pulses
   task send(input [31:0] w, input [15:0] es, input [15:0] eu, input [15:0] er);
      begin
         s0 = n_sel;
         u0 = n_uns;
         r0 = n_rx;
         @(negedge clk_in);
         word = w;
         valid = 1'b1;
         @(negedge clk_in);
         valid = 1'b0;
         while (rdy !== 1'b1) @(negedge clk_in);
         repeat (4) @(negedge clk_in);
         chk(es, n_sel - s0);
         chk(eu, n_uns - u0);
         chk(er, n_rx - r0);
         chk(16'h1, {15'h0, drn});
      end
   endtask

   initial begin
      #(25 * 20000);
      fails = fails + 1;
      end_sim;
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (8) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (4) @(negedge clk_in);
      for (i = 0; i < 9; i = i + 1) begin
         cfg(2'h0, 8'h01, 1'b0, 1'b1, i[3:0], 1'b0);
         send(32'h000000a5, 16'h8 + i[15:0] + {15'h0, i[0]}, 16'h0, 16'h1);
      end
      chk(16'h00a5, cap);
      $display("test lengths done");
      cfg(2'h1, 8'h03, 1'b1, 1'b0, 4'h0, 1'b0);
      send(32'h0001005a, 16'h9, 16'h0, 16'h1);
      cfg(2'h1, 8'h02, 1'b1, 1'b0, 4'h0, 1'b0);
      send(32'h0001005a, 16'h8, 16'h0, 16'h1);
      cfg(2'h2, 8'h01, 1'b1, 1'b0, 4'h0, 1'b0);
      send(32'h0002005a, 16'h9, 16'h0, 16'h1);
      send(32'h0002005a, 16'h8, 16'h0, 16'h1);
      $display("test dividers done");
      cfg(2'h2, 8'h01, 1'b0, 1'b1, 4'h0, 1'b1);
      send(32'h00020011, 16'h8, 16'h0, 16'h1);
      send(32'h00020022, 16'h10, 16'h0, 16'h2);
      @(negedge clk_in);
      word = 32'h01020000;
      valid = 1'b1;
      #1 chk(16'h0, {15'h0, drn});
      @(negedge clk_in);
      valid = 1'b0;
      chk(16'h1, {15'h0, cs_n[2]});
      // Without fixed selection a final word on a held select is sent, repeat included
      send(32'h00020033, 16'h8, 16'h0, 16'h1);
      fix = 1'b0;
      send(32'h01020077, 16'h10, 16'h0, 16'h2);
      chk(16'h1, {15'h0, cs_n[2]});
      fix = 1'b1;
      $display("test hold done");
      cfg(2'h0, 8'h01, 1'b0, 1'b1, 4'h2, 1'b0);
      cfg(2'h1, 8'h01, 1'b0, 1'b1, 4'h0, 1'b0);
      chk(16'h1, {15'h0, half});
      // Outside channel mode the last used select's own field counts
      chm = 1'b0;
      @(negedge clk_in);
      chk(16'h0, {15'h0, half});
      chm = 1'b1;
      cfg(2'h0, 8'h01, 1'b0, 1'b1, 4'h0, 1'b0);
      cfg(2'h1, 8'h01, 1'b0, 1'b1, 4'h0, 1'b0);
      chk(16'h0, {15'h0, half});
      $display("test word size done");
      pulse;
      send(32'h00010033, 16'h8, 16'h1, 16'h1);
      pulse;
      pulse;
      send(32'h00010033, 16'h8, 16'h0, 16'h1);
      // Bench keeps the select itself, so hold stays clear and a final word goes out whole
      send(32'h01010066, 16'h8, 16'h0, 16'h1);
      cfg(2'h1, 8'h01, 1'b0, 1'b1, 4'h0, 1'b1);
      @(negedge clk_in);
      word = 32'h00010044;
      valid = 1'b1;
      @(negedge clk_in);
      valid = 1'b0;
      while (rdy !== 1'b1) @(negedge clk_in);
      srst = 1'b1;
      @(negedge clk_in);
      srst = 1'b0;
      chk(16'h0, {15'h0, cs_n[1]});
      pulse;
      chk(16'h1, {15'h0, cs_n[1]});
      $display("test soft reset done");
      end_sim;
   end
endmodule
